//--- design/cpf_host.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
// Host-side framer: builds request payloads, checks response headers
// Behaviour
// - Payload is one header then one or more messages, all parsed.
// - Header: 2-byte transaction, 2-byte protocol, 2-byte length, unit byte.
// - Protocol identifier is 1 for version 1.
// - Length counts unit byte plus message bytes only.
// - Sender may zero header or message identifiers, or use both.
// - UDP uses the same header and port as TCP.
// - Tunnelling packs messages into one attribute in a control message.
// - Attribute header: mandatory, hidden, 4 reserved, 10-bit total length.
// - Then 16-bit vendor id and 16-bit type, both configurable.
// - Payload starts 6 reserved, 2-bit version, 8-bit unit identifier.
// - Reserved bits sent as zero, ignored on receive.
// - Mandatory flag set only if rejection should end the session.
// - Hidden flag set exactly when contents are encrypted.
// - Tunnel attribute carries no packet-level transaction identifier.
module cpf_host (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Software port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Outgoing byte stream
    output logic txValid,
    output logic txFirst,
    output logic [7:0] txData,
    input wire logic txReady,
    // Message body source
    output logic bodyReq,
    input wire logic [7:0] bodyData,
    input wire logic bodyLast,
    // Incoming byte stream
    input wire logic rxValid,
    input wire logic rxFirst,
    input wire logic rxLast,
    input wire logic [7:0] rxData,
    // Return code from message handler
    input wire logic codeValid,
    input wire logic [7:0] codeIn,
    // Status
    output logic busy,
    output logic rxGood,
    output logic rxBad
);
    typedef enum {CPF_IDLE, CPF_HEAD, CPF_BODY} cpf_state_type;

    logic rstSync1;
    logic rstSync2;
    logic rstN;
    cpf_state_type state;
    logic [31:0] ctrl;
    logic [15:0] transId;
    logic [7:0] subUnit;
    logic [15:0] bodyLen;
    logic [31:0] avpId;
    logic [3:0] byteIdx;
    logic [63:0] headBytes;
    logic [3:0] headCount;
    logic [7:0] worstCode;
    logic codeSeen;
    logic [7:0] codeCount;
    logic [7:0] badCodeCount;
    cpf_pkg::cpf_hdr_type rxHdr;
    logic rxHdrDone;
    logic [15:0] rxBodyCount;
    logic isSuccess;
    logic isReserved;
    logic isGeneric;
    logic codeClr;
    cpf_pkg::cpf_hdr_type txHdr;
    cpf_pkg::cpf_avp_type txAvp;
    logic [15:0] next_rxLen;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end
    assign rstN = rstSync2;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ctrl <= 32'h0000_0000;
            transId <= 16'h0000;
            subUnit <= 8'h00;
            bodyLen <= 16'h0000;
            avpId <= {cpf_pkg::AVP_VENDOR_DEF, cpf_pkg::AVP_TYPE_DEF};
        end else if (regWr) begin
            case (regAddr)
                cpf_pkg::REG_CTRL: ctrl <= regWdata;
                cpf_pkg::REG_TRANS: transId <= regWdata[15:0];
                cpf_pkg::REG_UNIT: subUnit <= regWdata[7:0];
                cpf_pkg::REG_LEN: bodyLen <= regWdata[15:0];
                cpf_pkg::REG_AVPID: avpId <= regWdata;
                default: ;
            endcase
        end else if (state == CPF_HEAD) begin
            ctrl[cpf_pkg::CTRL_SEND] <= 1'b0;
        end
    end

    // length is unit byte plus body
    // same framing for any datagram transport
    always_comb begin
        txHdr.transId = transId;
        txHdr.protoId = cpf_pkg::PROTO_VERSION;
        txHdr.length = bodyLen + cpf_pkg::UNIT_LEN;
        txHdr.subUnitSelector = subUnit;
    end

    // no packet transaction id in attribute
    always_comb begin
        txAvp.mandatory = ctrl[cpf_pkg::CTRL_MAND];
        txAvp.hidden = ctrl[cpf_pkg::CTRL_HIDDEN];
        txAvp.resvA = 4'h0;
        txAvp.length = bodyLen[9:0] + cpf_pkg::AVP_OVERHEAD;
        txAvp.vendorId = avpId[31:16];
        txAvp.attrType = avpId[15:0];
        // version and unit in payload head
        txAvp.resvB = 6'h00;
        txAvp.version = cpf_pkg::AVP_VERSION;
        txAvp.subUnitSelector = subUnit;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state <= CPF_IDLE;
            byteIdx <= 4'h0;
            headBytes <= 64'h0000_0000_0000_0000;
            headCount <= 4'h0;
            txValid <= 1'b0;
            txFirst <= 1'b0;
            txData <= 8'h00;
            busy <= 1'b0;
        end else begin
            case (state)
                CPF_IDLE: begin
                    // Last body byte stands until the far side takes it
                    if (!txValid || txReady) begin
                        txValid <= 1'b0;
                        txFirst <= 1'b0;
                        busy <= 1'b0;
                    end
                    if (ctrl[cpf_pkg::CTRL_SEND]) begin
                        state <= CPF_HEAD;
                        busy <= 1'b1;
                        byteIdx <= 4'h0;
                        if (ctrl[cpf_pkg::CTRL_TUNNEL]) begin
                            headBytes <= txAvp;
                            headCount <= 4'(cpf_pkg::AVP_BYTES);
                        end else begin
                            headBytes <= {txHdr, 8'h00};
                            headCount <= 4'(cpf_pkg::HDR_BYTES);
                        end
                    end
                end
                CPF_HEAD: begin
                    if (!txValid || txReady) begin
                        txValid <= 1'b1;
                        txFirst <= (byteIdx == 4'h0);
                        txData <= headBytes[63:56];
                        headBytes <= {headBytes[55:0], 8'h00};
                        byteIdx <= byteIdx + 4'h1;
                        if (byteIdx == headCount - 4'h1) begin
                            state <= CPF_BODY;
                        end
                    end
                end
                CPF_BODY: begin
                    // Source moves on one cycle after a request
                    if (!txValid || txReady) begin
                        txFirst <= 1'b0;
                        txValid <= !bodyReq;
                        if (!bodyReq) begin
                            txData <= bodyData;
                            if (bodyLast) begin
                                state <= CPF_IDLE;
                            end
                        end
                    end
                end
                default: state <= CPF_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            bodyReq <= 1'b0;
        end else begin
            bodyReq <= (state == CPF_BODY) && (!txValid || txReady)
                && !bodyReq && !bodyLast;
        end
    end

    cpf_hdr_parse u_parse (
        .clk(clk),
        .rstN(rstN),
        .rxValid(rxValid),
        .rxFirst(rxFirst),
        .rxData(rxData),
        .hdr(rxHdr),
        .hdrDone(rxHdrDone),
        .bodyCount(rxBodyCount)
    );

    always_comb begin
        next_rxLen = rxBodyCount + cpf_pkg::UNIT_LEN;
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rxGood <= 1'b0;
            rxBad <= 1'b0;
        end else begin
            // Clear first so that a check in the same cycle wins
            if (regWr && regAddr == cpf_pkg::REG_CTRL
                && regWdata[cpf_pkg::CTRL_RXCLR]) begin
                rxGood <= 1'b0;
                rxBad <= 1'b0;
            end
            if (rxValid && rxLast) begin
                if (rxHdr.protoId != cpf_pkg::PROTO_VERSION || !rxHdrDone
                    || rxHdr.length != next_rxLen) begin
                    rxBad <= 1'b1;
                end else if (rxHdr.transId == 16'h0000
                    || rxHdr.transId == transId) begin
                    rxGood <= 1'b1;
                end else begin
                    rxBad <= 1'b1;
                end
            end
        end
    end

    cpf_code_check u_code (
        .code(codeIn),
        .isSuccess(isSuccess),
        .isReserved(isReserved),
        .isUser(),
        .isGeneric(isGeneric)
    );

    assign codeClr = regWr && regAddr == cpf_pkg::REG_CODE;

    // error codes seen even when suppressed
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            worstCode <= cpf_pkg::RC_SUCCESS;
            codeSeen <= 1'b0;
            codeCount <= 8'h00;
            badCodeCount <= 8'h00;
        end else begin
            if (codeClr) begin
                worstCode <= cpf_pkg::RC_SUCCESS;
                codeSeen <= 1'b0;
                codeCount <= 8'h00;
                badCodeCount <= 8'h00;
            end
            // A code arriving with a clear is kept
            if (codeValid) begin
                codeCount <= (codeClr ? 8'h00 : codeCount) + 8'h01;
                if (!isSuccess
                    && (codeClr || !codeSeen || codeIn < worstCode)) begin
                    worstCode <= codeIn;
                    codeSeen <= 1'b1;
                end
                if (isReserved || isGeneric) begin
                    badCodeCount <= (codeClr ? 8'h00 : badCodeCount) + 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regRdata <= 32'h0000_0000;
        end else if (regRd) begin
            case (regAddr)
                cpf_pkg::REG_CTRL: regRdata <= ctrl;
                cpf_pkg::REG_TRANS: regRdata <= {16'h0000, transId};
                cpf_pkg::REG_UNIT: regRdata <= {24'h00_0000, subUnit};
                cpf_pkg::REG_LEN: regRdata <= {16'h0000, bodyLen};
                cpf_pkg::REG_AVPID: regRdata <= avpId;
                cpf_pkg::REG_STATUS:
                    regRdata <= {29'h0000_0000, rxBad, rxGood, busy};
                cpf_pkg::REG_RXHDR:
                    regRdata <= {rxHdr.transId, rxHdr.length};
                cpf_pkg::REG_RXUNIT:
                    regRdata <= {24'h00_0000, rxHdr.subUnitSelector};
                cpf_pkg::REG_CODE:
                    regRdata <= {8'h00, badCodeCount, codeCount, worstCode};
                default: regRdata <= 32'h0000_0000;
            endcase
        end else begin
            regRdata <= 32'h0000_0000;
        end
    end

    version_const_a: assert property (@(posedge clk) disable iff (!rstN)
        txHdr.protoId == 16'h0001) else $error("bad protocol id");
    length_rel_a: assert property (@(posedge clk) disable iff (!rstN)
        txHdr.length == bodyLen + 16'h0001) else $error("bad length");
    resv_zero_a: assert property (@(posedge clk) disable iff (!rstN)
        txAvp.resvA == 4'h0 && txAvp.resvB == 6'h00)
        else $error("reserved bits set");
    avp_len_a: assert property (@(posedge clk) disable iff (!rstN)
        txAvp.length == bodyLen[9:0] + 10'h008)
        else $error("bad attribute length");
    lowest_code_a: assert property (@(posedge clk) disable iff (!rstN)
        codeValid && codeSeen && codeIn != 8'h00 && codeIn < worstCode
        && !(regWr && regAddr == cpf_pkg::REG_CODE)
        |=> worstCode == $past(codeIn)) else $error("code not lowest");
    first_byte_a: assert property (@(posedge clk) disable iff (!rstN)
        txValid && txFirst |-> $past(state) == CPF_HEAD)
        else $error("first outside header");
    avp_ver_a: assert property (@(posedge clk) disable iff (!rstN)
        txAvp.version == 2'h1 && txAvp.subUnitSelector == subUnit)
        else $error("bad attribute version");
    discard_bad_a: assert property (@(posedge clk) disable iff (!rstN)
        rxValid && rxLast && rxHdrDone && rxHdr.protoId != 16'h0001
        && !regWr |=> rxBad) else $error("bad header kept");
endmodule : cpf_host

//--- design/cpf_pkg.sv
// Shared constants and carrier types for the control-plane framer host
package cpf_pkg;
    // Return codes
    localparam logic [7:0] RC_SUCCESS = 8'h00;
    localparam logic [7:0] RC_UNSUPPORTED = 8'h01;
    localparam logic [7:0] RC_BAD_LENGTH = 8'h02;
    localparam logic [7:0] RC_BAD_TRANS = 8'h03;
    localparam logic [7:0] RC_BAD_MODE = 8'h04;
    localparam logic [7:0] RC_BAD_ADDRESS = 8'h0A;
    localparam logic [7:0] RC_FAILURE = 8'h0C;
    localparam logic [7:0] RC_RESERVED_LO = 8'h0D;
    localparam logic [7:0] RC_RESERVED_HI = 8'h7F;
    localparam logic [7:0] RC_SLAVE_FAIL = 8'hFF;
    // Fixed header
    localparam int HDR_BYTES = 7;
    localparam logic [15:0] PROTO_VERSION = 16'h0001;
    localparam logic [15:0] UNIT_LEN = 16'h0001;
    // Tunnel attribute
    localparam int AVP_BYTES = 8;
    localparam logic [9:0] AVP_OVERHEAD = 10'h008;
    localparam logic [1:0] AVP_VERSION = 2'h1;
    localparam logic [15:0] AVP_VENDOR_DEF = 16'h0000;
    localparam logic [15:0] AVP_TYPE_DEF = 16'h0000;
    // Software register offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TRANS = 4'h1;
    localparam logic [3:0] REG_UNIT = 4'h2;
    localparam logic [3:0] REG_LEN = 4'h3;
    localparam logic [3:0] REG_AVPID = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;
    localparam logic [3:0] REG_RXHDR = 4'h6;
    localparam logic [3:0] REG_RXUNIT = 4'h7;
    localparam logic [3:0] REG_CODE = 4'h8;
    // Control bits
    localparam int CTRL_SEND = 0;
    localparam int CTRL_TUNNEL = 1;
    localparam int CTRL_HIDDEN = 2;
    localparam int CTRL_MAND = 3;
    localparam int CTRL_RXCLR = 4;

    typedef struct packed {
        logic [15:0] transId;
        logic [15:0] protoId;
        logic [15:0] length;
        logic [7:0] subUnitSelector;
    } cpf_hdr_type;

    typedef struct packed {
        logic mandatory;
        logic hidden;
        logic [3:0] resvA;
        logic [9:0] length;
        logic [15:0] vendorId;
        logic [15:0] attrType;
        logic [5:0] resvB;
        logic [1:0] version;
        logic [7:0] subUnitSelector;
    } cpf_avp_type;
endpackage : cpf_pkg

//--- design/cpf_code_check.sv
`timescale 1ns/1ps
// Classifies a received return code for the host
module cpf_code_check (
    // Code in
    input wire logic [7:0] code,
    // Class out
    output logic isSuccess,
    output logic isReserved,
    output logic isUser,
    output logic isGeneric
);
    always_comb begin
        isSuccess = (code == cpf_pkg::RC_SUCCESS);
        isReserved = (code >= cpf_pkg::RC_RESERVED_LO)
            && (code <= cpf_pkg::RC_RESERVED_HI);
        isUser = code[7] && (code != cpf_pkg::RC_SLAVE_FAIL);
        isGeneric = (code == cpf_pkg::RC_FAILURE);
    end
endmodule : cpf_code_check

//--- design/cpf_hdr_parse.sv
`timescale 1ns/1ps
// Collects the seven header bytes of a received payload and counts its unit byte plus body bytes
module cpf_hdr_parse (
    // Clock and reset
    input wire logic clk,
    input wire logic rstN,
    // Byte stream
    input wire logic rxValid,
    input wire logic rxFirst,
    input wire logic [7:0] rxData,
    // Result
    output cpf_pkg::cpf_hdr_type hdr,
    output logic hdrDone,
    output logic [15:0] bodyCount
);
    logic [2:0] idx;
    logic [47:0] shift;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            idx <= 3'h0;
            shift <= 48'h0000_0000_0000;
            hdr <= '0;
            hdrDone <= 1'b0;
            bodyCount <= 16'h0000;
        end else if (rxValid) begin
            if (rxFirst) begin
                idx <= 3'h1;
                shift <= {40'h00_0000_0000, rxData};
                hdrDone <= 1'b0;
                bodyCount <= 16'h0000;
            end else if (idx < 3'(cpf_pkg::HDR_BYTES - 1)) begin
                idx <= idx + 3'h1;
                shift <= {shift[39:0], rxData};
            end else if (idx == 3'(cpf_pkg::HDR_BYTES - 1)) begin
                idx <= idx + 3'h1;
                hdr <= {shift, rxData};
                hdrDone <= 1'b1;
                bodyCount <= 16'h0001;
            end else begin
                bodyCount <= bodyCount + 16'h0001;
            end
        end
    end
endmodule : cpf_hdr_parse

//--- bench/cpf_slave_model.sv
// Far-side device model: takes requests, returns replies and codes
`timescale 1ns/1ps
module cpf_slave_model (
    // Clock and pacing
    input wire logic clk,
    input wire logic slow,
    // Request stream
    input wire logic txValid,
    input wire logic txFirst,
    input wire logic [7:0] txData,
    output logic txReady,
    // Reply stream
    output logic rxValid,
    output logic rxFirst,
    output logic rxLast,
    output logic [7:0] rxData,
    // Return codes
    output logic codeValid,
    output logic [7:0] codeIn
);
    logic [8:0] txq[$];
    int seed = 5;

    initial begin
        txReady = 1'b0;
        rxValid = 1'b0;
        rxFirst = 1'b0;
        rxLast = 1'b0;
        rxData = 8'h00;
        codeValid = 1'b0;
        codeIn = 8'h00;
    end

    // Captures each accepted byte with its start flag
    always @(posedge clk) begin
        txReady <= slow ? 1'($random(seed)) : 1'b1;
        if (txValid && txReady)
            txq.push_back({txFirst, txData});
    end

    task automatic send_rsp(input logic [15:0] tid, pid, len,
                            input logic [7:0] unit, input int n);
        logic [7:0] b[$];
        b = {tid[15:8], tid[7:0], pid[15:8], pid[7:0],
             len[15:8], len[7:0], unit};
        repeat (n) b.push_back(8'($random(seed)));
        foreach (b[i]) begin
            @(posedge clk);
            rxValid <= 1'b1;
            rxFirst <= (i == 0);
            rxLast <= (i == b.size() - 1);
            rxData <= b[i];
        end
        @(posedge clk);
        rxValid <= 1'b0;
        rxFirst <= 1'b0;
        rxLast <= 1'b0;
        rxData <= ~b[b.size() - 1];
    endtask : send_rsp

    task automatic send_code(input logic [7:0] c);
        @(posedge clk);
        codeValid <= 1'b1;
        codeIn <= c;
        @(posedge clk);
        codeValid <= 1'b0;
        codeIn <= ~c;
    endtask : send_code
endmodule : cpf_slave_model

//--- bench/ctrl_plane_msg_framer_test.sv
// Self-checking bench for the control-plane framer host
`timescale 1ns/1ps
module ctrl_plane_msg_framer_test;
    logic clk;
    logic nrst = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic slow = 1'b0;
    logic [31:0] regRdata;
    logic txValid, txFirst, txReady, bodyReq, bodyLast;
    logic [7:0] txData, bodyData, rxData, codeIn;
    logic rxValid, rxFirst, rxLast, codeValid, busy, rxGood, rxBad;
    logic [7:0] body[16];
    logic [3:0] bIdx = 4'h0;
    logic [15:0] lenV = 16'h0001;
    int seed = 74223;
    int n_errors = 0;
    int comparisons = 0;

    cpf_host dut (.clk(clk), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .txValid(txValid), .txFirst(txFirst),
        .txData(txData), .txReady(txReady), .bodyReq(bodyReq),
        .bodyData(bodyData), .bodyLast(bodyLast), .rxValid(rxValid),
        .rxFirst(rxFirst), .rxLast(rxLast), .rxData(rxData),
        .codeValid(codeValid), .codeIn(codeIn), .busy(busy),
        .rxGood(rxGood), .rxBad(rxBad));
    cpf_slave_model model (.clk(clk), .slow(slow), .txValid(txValid),
        .txFirst(txFirst), .txData(txData), .txReady(txReady),
        .rxValid(rxValid), .rxFirst(rxFirst), .rxLast(rxLast),
        .rxData(rxData), .codeValid(codeValid), .codeIn(codeIn));

    // Message body source, one byte per request
    assign bodyData = body[bIdx];
    assign bodyLast = (bIdx == lenV[3:0] - 4'h1);
    always @(posedge clk) begin
        if (bodyReq)
            bIdx <= bIdx + 4'h1;
    end

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        @(negedge clk);
        v = regRdata;
    endtask : rd

    // Sends one request and compares every byte on the stream
    task automatic run_tx(input logic [3:0] ctl);
        logic [7:0] e[$];
        logic [15:0] tid;
        logic [7:0] un;
        logic [31:0] ids;
        cpf_pkg::cpf_hdr_type h;
        cpf_pkg::cpf_avp_type a;
        int k;
        tid = 16'($random(seed));
        un = 8'($random(seed));
        ids = $random(seed);
        lenV = 16'({$random(seed)} % 8 + 1);
        foreach (body[i]) body[i] = 8'($random(seed));
        wr(cpf_pkg::REG_TRANS, {16'h0000, tid});
        wr(cpf_pkg::REG_UNIT, {24'h00_0000, un});
        wr(cpf_pkg::REG_LEN, {16'h0000, lenV});
        wr(cpf_pkg::REG_AVPID, ids);
        h = '{tid, cpf_pkg::PROTO_VERSION, lenV + cpf_pkg::UNIT_LEN, un};
        a = '{ctl[cpf_pkg::CTRL_MAND], ctl[cpf_pkg::CTRL_HIDDEN], 4'h0,
              lenV[9:0] + cpf_pkg::AVP_OVERHEAD, ids[31:16], ids[15:0],
              6'h00, cpf_pkg::AVP_VERSION, un};
        for (int i = 0; i < (ctl[1] ? 8 : 7); i++)
            e.push_back(ctl[1] ? a[63 - 8 * i -: 8] : h[55 - 8 * i -: 8]);
        for (int i = 0; i < lenV; i++)
            e.push_back(body[i]);
        @(posedge clk);
        bIdx <= 4'h0;
        wr(cpf_pkg::REG_CTRL, {28'h000_0000, ctl});
        repeat (2) @(posedge clk);
        k = 0;
        while (busy !== 1'b0 && k < 500) begin
            @(posedge clk);
            k++;
        end
        check(model.txq.size(), e.size());
        foreach (e[i]) begin
            if (i < model.txq.size())
                check(model.txq[i], {i == 0, e[i]});
        end
        model.txq.delete();
    endtask : run_tx

    initial begin
        logic [31:0] d;
        logic [31:0] msk;
        logic [15:0] tr, tid, pid, ln;
        logic [7:0] c, mn, un;
        logic [7:0] tbl[7];
        int n, k, rc;
        tbl = '{8'hFF, 8'h80, 8'h0D, 8'h00, 8'h0C, 8'h7F, 8'hFE};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset values, readback, unmapped places
        for (int i = 1; i < 5; i++) begin
            msk = (i == 4) ? 32'hFFFF_FFFF : (i == 2) ? 32'h0000_00FF :
                  (i == 3) ? 32'h0000_00FF : 32'h0000_FFFF;
            rd(4'(i), d);
            check(d, 32'h0000_0000);
            wr(4'(i), $random(seed) & msk);
            rd(4'(i), d);
            check(d, regWdata);
        end
        wr(4'hF, $random(seed));
        rd(4'hF, d);
        check(d, 32'h0000_0000);
        rd(4'h9, d);
        check(d, 32'h0000_0000);
        $display("register test done");
        // Plain and tunnel framing, prompt and stalling far side
        run_tx(4'b0001);
        slow <= 1'b1;
        run_tx(4'b0001);
        for (int i = 0; i < 4; i++) begin
            slow <= 1'(i);
            run_tx({2'(i), 2'b11});
        end
        slow <= 1'b0;
        $display("transmit test done");
        // Header checks on replies
        tr = 16'($random(seed)) | 16'h0001;
        wr(cpf_pkg::REG_TRANS, {16'h0000, tr});
        for (int i = 0; i < 6; i++) begin
            n = {$random(seed)} % 6 + 1;
            tid = (i == 0) ? 16'h0000 : (i == 2) ? tr ^ 16'h0002 : tr;
            pid = (i == 3) ? 16'h0002 : 16'h0001;
            ln = 16'(n + 1) + ((i == 4) ? 16'h0001 : 16'h0000)
                 - ((i == 5) ? 16'h0001 : 16'h0000);
            un = 8'($random(seed));
            model.send_rsp(tid, pid, ln, un, n);
            k = 0;
            while (rxGood !== 1'b1 && rxBad !== 1'b1 && k < 20) begin
                @(posedge clk);
                k++;
            end
            check({rxGood, rxBad}, (i < 2) ? 2'b10 : 2'b01);
            rd(cpf_pkg::REG_RXHDR, d);
            check(d, {tid, ln});
            rd(cpf_pkg::REG_RXUNIT, d);
            check(d, {24'h00_0000, un});
            wr(cpf_pkg::REG_CTRL, 32'h0000_0010);
            @(posedge clk);
            check({rxGood, rxBad}, 2'b00);
        end
        $display("receive test done");
        // Return codes: lowest wins, reserved and generic counted
        wr(cpf_pkg::REG_CODE, 32'h0000_0000);
        mn = 8'h00;
        rc = 0;
        for (int i = 0; i < 10; i++) begin
            c = (i < 7) ? tbl[i] : 8'($random(seed));
            model.send_code(c);
            if (c != 8'h00 && (mn == 8'h00 || c < mn))
                mn = c;
            if (c >= 8'h0C && c <= 8'h7F)
                rc++;
        end
        repeat (2) @(posedge clk);
        rd(cpf_pkg::REG_CODE, d);
        check(d[7:0], mn);
        check(d[15:8], 8'h0A);
        check(d[23:16], 8'(rc));
        wr(cpf_pkg::REG_CODE, 32'h0000_0000);
        rd(cpf_pkg::REG_CODE, d);
        check(d, 32'h0000_0000);
        $display("code test done");
        close_out();
    end

    initial begin
        repeat (30000) @(posedge clk);
        n_errors++;
        close_out();
    end
endmodule : ctrl_plane_msg_framer_test
